// ===== adm_top.sv
`timescale 1ns/1ps
`include "adm_defs.svh"

module adm_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire adm_pkg::adm_result_t left_sample,
    input wire adm_pkg::adm_result_t right_sample,
    input wire logic sample_valid
);
    import adm_pkg::*;

    // Register state
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_a_d;
    logic [7:0] cfg_b_q;
    logic [7:0] cfg_b_d;
    adm_bus_state_t bus_q;
    adm_bus_state_t bus_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;

    // Averaging period timer
    logic [19:0] per_cnt_q;
    logic [19:0] per_cnt_d;

    // Per-channel result path
    adm_result_t live_q [`ADM_NUM_CH];
    adm_result_t snap_q [`ADM_NUM_CH];
    adm_result_t res_q [`ADM_NUM_CH];
    adm_result_t pick [`ADM_NUM_CH];
    logic ch_en [`ADM_NUM_CH];
    adm_result_t ch_sample [`ADM_NUM_CH];

    adm_chan_if ch_if [`ADM_NUM_CH] ();

    // Bus decode
    wire [`ADM_IDX_W-1:0] idx = wb_adr_i[8:2];
    wire req = wb_cyc_i && wb_stb_i;
    wire accept = req && (bus_q == ADM_BUS_IDLE);
    // Write lands on the edge the master sees ack
    wire wr_en = req && wb_we_i && (bus_q == ADM_BUS_ACK) && wb_sel_i[0];
    wire hit_a = (idx == `ADM_IDX_CFG_A);
    wire hit_b = (idx == `ADM_IDX_CFG_B);

    // Configuration fields
    wire left_en = cfg_a_q[`ADM_A_LEFT_EN];
    wire right_en = cfg_a_q[`ADM_A_RIGHT_EN];
    wire iir_mode = cfg_a_q[`ADM_A_IIR_MODE];
    wire [4:0] d_raw = cfg_a_q[4:0];
    wire freeze = cfg_b_q[`ADM_B_FREEZE];
    wire snap_sel = cfg_b_q[`ADM_B_SNAP_SEL];
    wire [4:0] avg_raw = cfg_b_q[4:0];

    wire d_low = (d_raw < `ADM_D_MIN);
    wire d_high = (d_raw > `ADM_D_MAX);
    wire [4:0] d_eff = d_low ? `ADM_D_MIN : (d_high ? `ADM_D_MAX : d_raw);

    wire avg_high = (avg_raw > `ADM_AVG_MAX);
    wire [4:0] avg_eff = avg_high ? `ADM_AVG_MAX : avg_raw;
    wire avg_inf = (avg_eff == `ADM_AVG_INFINITE);
    wire [19:0] per_last = 20'((21'h000001 << avg_eff) - 21'h000001);
    wire any_en = left_en || right_en;
    wire timer_run = any_en && iir_mode && !avg_inf;
    wire per_clr = timer_run && (per_cnt_q == per_last);

    assign ch_en[0] = left_en;
    assign ch_en[1] = right_en;
    assign ch_sample[0] = left_sample;
    assign ch_sample[1] = right_sample;

    genvar g;
    generate
        for (g = 0; g < `ADM_NUM_CH; g++) begin : g_ch
            assign ch_if[g].enable = ch_en[g];
            assign ch_if[g].iir_mode = iir_mode;
            assign ch_if[g].d_shift = d_eff;
            assign ch_if[g].period_clr = per_clr;
            assign ch_if[g].sample = ch_sample[g];
            assign ch_if[g].sample_vld = sample_valid;

            adm_filter u_filter (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .ch(ch_if[g])
            );

            assign pick[g] = (iir_mode && snap_sel) ? snap_q[g] : live_q[g];

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    live_q[g] <= `ADM_RESULT_RST;
                end else if (ch_if[g].avg_vld) begin
                    live_q[g] <= ch_if[g].avg_out;
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    snap_q[g] <= `ADM_RESULT_RST;
                end else if (per_clr && ch_en[g]) begin
                    snap_q[g] <= ch_if[g].avg_out;
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    res_q[g] <= `ADM_RESULT_RST;
                end else if (!freeze) begin
                    res_q[g] <= pick[g];
                end
            end
        end
    endgenerate

    // Period counter restarts whenever the timer stops
    always_comb begin
        per_cnt_d = per_cnt_q + 20'h00001;
        if (!timer_run || per_clr) begin
            per_cnt_d = 20'h00000;
        end
    end

    // Configuration writes
    always_comb begin
        cfg_a_d = cfg_a_q;
        cfg_b_d = cfg_b_q;
        if (wr_en && hit_a) begin
            cfg_a_d = wb_dat_i[7:0];
        end
        if (wr_en && hit_b) begin
            cfg_b_d = wb_dat_i[7:0] & `ADM_B_WRITE_MASK;
        end
    end

    // Read selection; reserved and unmapped read zero
    always_comb begin
        rdat_d = 32'h00000000;
        case (idx)
            `ADM_IDX_CFG_A: rdat_d[7:0] = cfg_a_q;
            `ADM_IDX_CFG_B: rdat_d[7:0] = cfg_b_q;
            `ADM_IDX_L_HIGH: rdat_d[7:0] = res_q[0][23:16];
            `ADM_IDX_L_MID: rdat_d[7:0] = res_q[0][15:8];
            `ADM_IDX_L_LOW: rdat_d[7:0] = res_q[0][7:0];
            `ADM_IDX_R_HIGH: rdat_d[7:0] = res_q[1][23:16];
            `ADM_IDX_R_MID: rdat_d[7:0] = res_q[1][15:8];
            `ADM_IDX_R_LOW: rdat_d[7:0] = res_q[1][7:0];
            default: rdat_d = 32'h00000000;
        endcase
    end

    // Bus handshake: ack one cycle after the request, then drop
    always_comb begin
        case (bus_q)
            ADM_BUS_IDLE: begin
                bus_d = accept ? ADM_BUS_ACK : ADM_BUS_IDLE;
            end
            ADM_BUS_ACK: begin
                bus_d = ADM_BUS_IDLE;
            end
            default: begin
                bus_d = ADM_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= ADM_BUS_IDLE;
            rdat_q <= 32'h00000000;
        end else begin
            bus_q <= bus_d;
            rdat_q <= accept ? rdat_d : rdat_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_a_q <= `ADM_CFG_A_RST;
            cfg_b_q <= `ADM_CFG_B_RST;
        end else begin
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_q <= 20'h00000;
        end else begin
            per_cnt_q <= per_cnt_d;
        end
    end

    assign wb_ack_o = (bus_q == ADM_BUS_ACK);
    assign wb_dat_o = rdat_q;
endmodule : adm_top

// ===== adm_defs.svh
`ifndef ADM_DEFS_SVH
`define ADM_DEFS_SVH

// Register indices; byte address is four times the index
`define ADM_IDX_W 7
`define ADM_IDX_CFG_A 7'h66
`define ADM_IDX_CFG_B 7'h67
`define ADM_IDX_L_HIGH 7'h68
`define ADM_IDX_L_MID 7'h69
`define ADM_IDX_L_LOW 7'h6A
`define ADM_IDX_R_HIGH 7'h6B
`define ADM_IDX_R_MID 7'h6C
`define ADM_IDX_R_LOW 7'h6D
`define ADM_IDX_RSV_FIRST 7'h6E
`define ADM_IDX_RSV_LAST 7'h7F

// Reset values
`define ADM_CFG_A_RST 8'h00
`define ADM_CFG_B_RST 8'h00
`define ADM_RESULT_RST 24'h000000

// Field positions, configuration A
`define ADM_A_LEFT_EN 7
`define ADM_A_RIGHT_EN 6
`define ADM_A_IIR_MODE 5
// Field positions, configuration B
`define ADM_B_FREEZE 6
`define ADM_B_SNAP_SEL 5
`define ADM_B_WRITE_MASK 8'h7F

// Field values and limits
`define ADM_FIELD_W 5
`define ADM_D_MIN 5'h01
`define ADM_D_MAX 5'h14
`define ADM_AVG_INFINITE 5'h00
`define ADM_AVG_MAX 5'h14
`define ADM_FRAC_W 20
`define ADM_SAMPLE_W 24
`define ADM_NUM_CH 2

`endif

// ===== adm_pkg.sv
`include "adm_defs.svh"

package adm_pkg;
    typedef logic signed [`ADM_SAMPLE_W-1:0] adm_result_t;
    typedef logic [`ADM_FIELD_W-1:0] adm_field_t;
    typedef enum logic [1:0] {
        ADM_BUS_IDLE = 2'b01,
        ADM_BUS_ACK = 2'b10
    } adm_bus_state_t;
endpackage : adm_pkg

// ===== adm_chan_if.sv
`timescale 1ns/1ps

interface adm_chan_if;
    import adm_pkg::*;
    logic enable;
    logic iir_mode;
    adm_field_t d_shift;
    logic period_clr;
    adm_result_t sample;
    logic sample_vld;
    adm_result_t avg_out;
    logic avg_vld;
    modport filt (
        input enable,
        input iir_mode,
        input d_shift,
        input period_clr,
        input sample,
        input sample_vld,
        output avg_out,
        output avg_vld
    );
    modport ctrl (
        output enable,
        output iir_mode,
        output d_shift,
        output period_clr,
        output sample,
        output sample_vld,
        input avg_out,
        input avg_vld
    );
endinterface : adm_chan_if

// ===== adm_filter.sv
`timescale 1ns/1ps
`include "adm_defs.svh"

module adm_filter (
    input wire logic core_clk,
    input wire logic rst_n,
    adm_chan_if.filt ch
);
    import adm_pkg::*;

    logic signed [44:0] acc_q;
    logic signed [44:0] acc_d;
    logic [20:0] cnt_q;
    logic [20:0] cnt_d;
    logic signed [43:0] y_q;
    logic signed [43:0] y_d;
    adm_result_t out_q;
    adm_result_t out_d;
    logic vld_q;
    logic vld_d;

    wire [20:0] len_last = 21'((21'h000001 << ch.d_shift) - 21'h000001);
    wire signed [44:0] acc_sum = acc_q + 45'(ch.sample);
    wire signed [44:0] ma_avg = acc_sum >>> ch.d_shift;
    wire signed [43:0] x_ext = {ch.sample, {`ADM_FRAC_W{1'b0}}};
    wire signed [44:0] diff = 45'(x_ext) - 45'(y_q);
    wire signed [44:0] step = diff >>> ch.d_shift;
    wire signed [43:0] y_next = y_q + 44'(step);

    always_comb begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        y_d = y_q;
        out_d = out_q;
        vld_d = 1'b0;
        if (!ch.enable) begin
            acc_d = '0;
            cnt_d = '0;
            y_d = '0;
        end else if (ch.iir_mode) begin
            acc_d = '0;
            cnt_d = '0;
            if (ch.period_clr) begin
                y_d = '0;
            end else if (ch.sample_vld) begin
                y_d = y_next;
                out_d = y_next[43:`ADM_FRAC_W];
                vld_d = 1'b1;
            end
        end else begin
            y_d = '0;
            if (ch.sample_vld) begin
                if (cnt_q == len_last) begin
                    acc_d = '0;
                    cnt_d = '0;
                    out_d = ma_avg[23:0];
                    vld_d = 1'b1;
                end else begin
                    acc_d = acc_sum;
                    cnt_d = cnt_q + 21'h000001;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            cnt_q <= '0;
            y_q <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            y_q <= y_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign ch.avg_out = out_q;
    assign ch.avg_vld = vld_q;
endmodule : adm_filter

// ===== adm_top_checker.sv
`timescale 1ns/1ps
module adm_top_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire adm_pkg::adm_result_t left_sample,
    input wire adm_pkg::adm_result_t right_sample,
    input wire logic sample_valid
);
    import adm_pkg::*;
    logic [7:0] cfga_q;
    logic [7:0] cfgb_q;
    wire [6:0] idx = wb_adr_i[8:2];
    wire wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire rd_ok = wb_ack_o && !wb_we_i;
    // Shadow of the configuration bytes, bit 7 of B never sticks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfga_q <= 8'h00;
            cfgb_q <= 8'h00;
        end else if (wr_ok && idx == 7'h66) begin
            cfga_q <= wb_dat_i[7:0];
        end else if (wr_ok && idx == 7'h67) begin
            cfgb_q <= wb_dat_i[7:0] & 8'h7F;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_data_held: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_rsv_zero: assert property (rd_ok && idx >= 7'h6E |-> wb_dat_o == 32'h00000000)
        else $error("reserved place not zero");
    a_cfga_back: assert property (rd_ok && idx == 7'h66 |-> wb_dat_o[7:0] == cfga_q)
        else $error("config A readback wrong");
    a_cfgb_back: assert property (rd_ok && idx == 7'h67 |-> wb_dat_o[7:0] == cfgb_q)
        else $error("config B readback wrong");
    c_write: cover property (wr_ok);
    c_rsv: cover property (rd_ok && idx >= 7'h6E);
    c_sample: cover property (sample_valid);
endmodule : adm_top_checker

bind adm_top adm_top_checker adm_top_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid));

// ===== adc_dc_measurement_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module adc_dc_measurement_tb;
    import adm_pkg::*;
    logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sample_valid;
    logic [8:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    adm_result_t left_sample, right_sample;
    int n_mismatch = 0, compares = 0, cycles = 0;
    adm_top adm_top_i (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // Whole run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic xfer(input logic we, input logic [3:0] sel, input logic [6:0] idx,
                        input logic [7:0] wd);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        // The wait ends on ack; with no ack, only the bench timeout ends it
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer
    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        xfer(1'b0, 4'h1, idx, 8'h00);
        `CHK(rd, {24'h000000, exp})
    endtask : rd_chk
    // High byte first, so byte order slips show up
    task automatic res_chk(input logic [6:0] base, input logic [23:0] exp);
        rd_chk(base, exp[23:16]);
        rd_chk(base + 7'h01, exp[15:8]);
        rd_chk(base + 7'h02, exp[7:0]);
    endtask : res_chk
    task automatic feed(input logic [23:0] l, input logic [23:0] r, input int cnt);
        repeat (cnt) begin
            @(posedge core_clk);
            sample_valid <= 1'b1;
            left_sample <= l;
            right_sample <= r;
        end
        @(posedge core_clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : feed
    task automatic t_reset();
        for (int i = 'h66; i <= 'h6E; i++) rd_chk(7'(i), 8'h00);
        rd_chk(7'h7F, 8'h00);
        rd_chk(7'h04, 8'h00);
    endtask : t_reset
    task automatic t_regs();
        xfer(1'b1, 4'h1, 7'h66, 8'hF4);
        xfer(1'b1, 4'h0, 7'h66, 8'h00);
        rd_chk(7'h66, 8'hF4);
        xfer(1'b1, 4'h1, 7'h67, 8'hF4);
        rd_chk(7'h67, 8'h74);
        xfer(1'b1, 4'h1, 7'h6E, 8'hFF);
        rd_chk(7'h6E, 8'h00);
        xfer(1'b1, 4'h1, 7'h68, 8'hFF);
        rd_chk(7'h68, 8'h00);
    endtask : t_regs
    task automatic t_ma();
        xfer(1'b1, 4'h1, 7'h67, 8'h00);
        xfer(1'b1, 4'h1, 7'h66, 8'h82);
        for (int i = 1; i <= 4; i++) feed(24'(i * 'h100), 24'h7FFFFF, 1);
        res_chk(7'h68, 24'h000280);
        res_chk(7'h6B, 24'h000000);
        feed(24'hFFFFFC, 24'h7FFFFF, 4);
        res_chk(7'h68, 24'hFFFFFC);
    endtask : t_ma
    task automatic t_iir();
        xfer(1'b1, 4'h1, 7'h66, 8'h61);
        feed(24'h000000, 24'h000100, 3);
        res_chk(7'h6B, 24'h0000E0);
        res_chk(7'h68, 24'hFFFFFC);
    endtask : t_iir
    task automatic t_freeze();
        xfer(1'b1, 4'h1, 7'h67, 8'h40);
        feed(24'h000000, 24'h000100, 2);
        res_chk(7'h6B, 24'h0000E0);
        xfer(1'b1, 4'h1, 7'h67, 8'h00);
        feed(24'h000000, 24'h000100, 1);
        res_chk(7'h6B, 24'h0000FC);
    endtask : t_freeze
    // Clear every 2 clocks: each kept sample starts from zero
    task automatic t_snap();
        xfer(1'b1, 4'h1, 7'h67, 8'h21);
        feed(24'h000000, 24'h000100, 2);
        res_chk(7'h6B, 24'h000080);
        res_chk(7'h68, 24'h000000);
        xfer(1'b1, 4'h1, 7'h66, 8'h80);
        feed(24'h000010, 24'h000000, 1);
        feed(24'h000030, 24'h000000, 1);
        res_chk(7'h68, 24'h000020);
    endtask : t_snap
    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, sample_valid} = 4'h0;
        wb_sel_i = 4'h0;
        wb_adr_i = 9'h000;
        wb_dat_i = 32'h00000000;
        left_sample = 24'h000000;
        right_sample = 24'h000000;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_ma();
        t_iir();
        t_freeze();
        t_snap();
        conclude();
    end
endmodule : adc_dc_measurement_tb
